// ===== ieol_pkg.sv
/*
  Shared constants for the I2C eight-bit output latch: widths, bus
  address layout, subaddress command codes and reset values.
  Assumes nothing of its surroundings; imported whole by each module except ieol_bus_master.
*/
package ieol_pkg;
  localparam int DATA_W = 8;
  localparam int STRAP_W = 3;
  localparam int GROUP_W = 4;
  localparam int BIT_CNT_W = 4;
  // Group identifier in the upper address bits; value is arbitrary
  localparam logic [GROUP_W-1:0] GROUP_ID_DEF = 4'hA;
  // Subaddress codes decoded into the three internal strobes
  localparam logic [DATA_W-1:0] SUB_WRITE = 8'h11;
  localparam logic [DATA_W-1:0] SUB_READ = 8'h22;
  localparam logic [DATA_W-1:0] SUB_XFER = 8'h44;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_DATA, ST_DATA_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
  } ieol_state_e;
endpackage : ieol_pkg

// ===== ieol_sync.sv
/*
  Two-flop synchroniser bank, one chain per bit.
  Assumes each input bit is quasi-static relative to ref_clk; the
  first stage is read only by the second stage.
*/
`timescale 1ns/10ps
module ieol_sync
  import ieol_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  genvar i;
  // One metastability chain per bit
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q <= RESET_VAL[i];
          stable_q <= RESET_VAL[i];
        end else begin
          meta_q <= asyncIn[i];
          stable_q <= meta_q;
        end
      end
      assign syncOut[i] = stable_q;
    end
  endgenerate
endmodule : ieol_sync

// ===== ieol_latch.sv
/*
  I2C-addressed eight-bit output latch: bus slave, serial shift
  register, storage register and gated low-side sink drive.
  Assumes ref_clk oversamples SCL by a wide margin (100 MHz against at
  most a few MHz) and that SDA/SCL are resolved outside from sdaOe.
*/
`timescale 1ns/10ps
// Functional notes
// - An 8-bit serial-in shift register loads in parallel into an 8-bit storage register that drives the outputs.
// - Data bits enter the shift register only after group and device address have matched.
// - Subaddress 11H writes the shift register, 22H selects read-back and 44H moves the shift byte to storage.
// - With the active-low output enable high, all sink outputs are off.
// - With the output enable low and no over-temperature indication, each storage bit passes straight to its output.
// - A one turns the sink on, a zero turns it off.
// - Power-up clear puts every register into the all-outputs-off state.
// - An over-temperature indication forces all sink outputs off.
// - Eight independent sink outputs, one per storage bit.
// - SDA is driven only as an open-drain pull-down and is also sampled.
// - Power-up clear also returns the bus interface to idle.
module ieol_latch
  import ieol_pkg::*;
#(
  parameter logic [GROUP_W-1:0] GROUP_ID = GROUP_ID_DEF,
  parameter int WIDTH = DATA_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic outEnable_n,
  input wire logic overTemp,
  output logic [WIDTH-1:0] sink_outputs
);
  localparam int N_SYNC = 4 + STRAP_W;

  logic [N_SYNC-1:0] pinsRaw;
  logic [N_SYNC-1:0] pinsSync;
  logic sclS;
  logic sdaS;
  logic outEnableS_n;
  logic overTempS;
  logic [STRAP_W-1:0] strapS;

  ieol_state_e state_q;
  ieol_state_e state_d;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic [DATA_W-1:0] rxByte_q;
  logic [WIDTH-1:0] shiftReg_q;
  logic [WIDTH-1:0] storage_q;
  logic [WIDTH-1:0] txByte_q;
  logic [DATA_W-1:0] subAddr_q;
  logic [BIT_CNT_W-1:0] bitCnt_q;
  logic readStorage_q;
  logic readWrite_q;
  logic masterAck_q;
  logic sdaOe_q;
  logic sdaOut_q;
  logic [WIDTH-1:0] sink_q;

  // Pins cross into ref_clk; SCL/SDA idle high, enable idles off
  assign pinsRaw = {scl, sdaIn, outEnable_n, overTemp,
                    addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

  ieol_sync #(
    .WIDTH(N_SYNC),
    .RESET_VAL(7'h70)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .asyncIn(pinsRaw),
    .syncOut(pinsSync)
  );

  assign sclS = pinsSync[6];
  assign sdaS = pinsSync[5];
  assign outEnableS_n = pinsSync[4];
  assign overTempS = pinsSync[3];
  assign strapS = pinsSync[2:0];

  // Bus event decode from synchronised levels
  wire sclRise = sclS & ~sclPrev_q;
  wire sclFall = ~sclS & sclPrev_q;
  wire startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  wire stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  wire byteDone = (bitCnt_q == BITS_PER_BYTE);
  wire addrMatch = (rxByte_q[7:4] == GROUP_ID) &&
                   (rxByte_q[3:1] == strapS);
  wire isWrite = (rxByte_q == SUB_WRITE);
  wire isRead = (rxByte_q == SUB_READ);
  wire isXfer = (rxByte_q == SUB_XFER);
  wire subValid = isWrite | isRead | isXfer;
  wire receiving = (state_q == ST_ADDR) || (state_q == ST_SUB) ||
                   (state_q == ST_DATA);
  wire rxShift = receiving & sclRise & ~byteDone;
  // Data bits commit on the SCL fall after sampling, so the rising SCL
  // of a stop is never taken as one more bit
  wire dataShift = (state_q == ST_DATA) & sclFall &
                   (bitCnt_q != '0);
  wire xferStrobe = (state_q == ST_SUB) & sclFall & byteDone &
                    isXfer;
  wire readSelStrobe = (state_q == ST_SUB) & sclFall & byteDone &
                       subValid;
  wire [WIDTH-1:0] readSource = readStorage_q ? storage_q : shiftReg_q;
  // Gate: enable low and no overload, else every sink is off
  wire sinkEnable = ~outEnableS_n & ~overTempS;
  wire [WIDTH-1:0] sinkNext = sinkEnable ? storage_q :
                              REG_RESET;
  wire txBit = txByte_q[3'(WIDTH - 1 - int'(bitCnt_q))];

  // Next state; start and stop override any phase
  always_comb begin
    state_d = state_q;
    if (startSeen) begin
      state_d = ST_ADDR;
    end else if (stopSeen) begin
      state_d = ST_IDLE;
    end else if (sclFall) begin
      case (state_q)
        ST_ADDR: begin
          if (byteDone) begin
            state_d = addrMatch ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK: state_d = readWrite_q ? ST_RD : ST_SUB;
        ST_SUB: begin
          if (byteDone) begin
            state_d = subValid ? ST_SUB_ACK : ST_IGNORE;
          end
        end
        ST_SUB_ACK: state_d = (subAddr_q == SUB_WRITE) ? ST_DATA :
                              ST_IGNORE;
        ST_DATA: begin
          if (byteDone) begin
            state_d = ST_DATA_ACK;
          end
        end
        ST_DATA_ACK: state_d = ST_DATA;
        ST_RD: begin
          if (byteDone) begin
            state_d = ST_RD_ACK;
          end
        end
        ST_RD_ACK: state_d = masterAck_q ? ST_RD : ST_IGNORE;
        default: state_d = state_q;
      endcase
    end
  end

  // State, edge history and bit counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      bitCnt_q <= '0;
    end else begin
      state_q <= state_d;
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
      if (startSeen || (sclFall && state_d != state_q)) begin
        bitCnt_q <= '0;
      end else if (sclRise && !byteDone &&
                   (receiving || state_q == ST_RD)) begin
        bitCnt_q <= bitCnt_q + 4'h1;
      end
    end
  end

  // Received byte, serial shift and captured subaddress
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxByte_q <= REG_RESET;
      shiftReg_q <= REG_RESET;
      subAddr_q <= REG_RESET;
      readWrite_q <= 1'b0;
    end else begin
      if (rxShift) begin
        rxByte_q <= {rxByte_q[DATA_W-2:0], sdaS};
      end
      if (dataShift) begin
        shiftReg_q <= {shiftReg_q[WIDTH-2:0], rxByte_q[0]};
      end
      if (readSelStrobe) begin
        subAddr_q <= rxByte_q;
      end
      if (state_q == ST_ADDR && sclFall && byteDone) begin
        readWrite_q <= rxByte_q[0];
      end
    end
  end

  // Storage register and read-back source select
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      storage_q <= REG_RESET;
      readStorage_q <= 1'b0;
    end else begin
      if (xferStrobe) begin
        storage_q <= shiftReg_q;
      end
      if (readSelStrobe) begin
        readStorage_q <= isRead;
      end
    end
  end

  // Transmit byte and master acknowledge capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txByte_q <= REG_RESET;
      masterAck_q <= 1'b0;
    end else begin
      if (sclFall && state_d == ST_RD && state_q != ST_RD) begin
        txByte_q <= readSource;
      end
      if (state_q == ST_RD_ACK && sclRise) begin
        masterAck_q <= ~sdaS;
      end
    end
  end

  // SDA pull-down: ack slots and zero read bits, changed on SCL fall
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOe_q <= 1'b0;
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
      if (startSeen || stopSeen) begin
        sdaOe_q <= 1'b0;
      end else if (sclFall) begin
        case (state_d)
          ST_ADDR_ACK, ST_SUB_ACK, ST_DATA_ACK: sdaOe_q <= 1'b1;
          ST_RD: begin
            // First bit comes from the freshly selected source
            if (state_q != ST_RD) begin
              sdaOe_q <= ~readSource[WIDTH-1];
            end else begin
              sdaOe_q <= ~txBit;
            end
          end
          default: sdaOe_q <= 1'b0;
        endcase
      end
    end
  end

  // Registered sink drive; overload and enable act within 3 clocks
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sink_q <= REG_RESET;
    end else begin
      sink_q <= sinkNext;
    end
  end

  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign sink_outputs = sink_q;
endmodule : ieol_latch

// ===== ieol_bus_master.sv
/*
  I2C bus master model: drives SCL and pulls SDA low, open drain.
  Assumes SDA is resolved outside with a pull-up.
*/
`timescale 1ns/10ps
module ieol_bus_master #(
  parameter int HALF = 20
) (
  input wire logic ref_clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  // Idle bus: SCL stands high and SDA is released
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hold;
    repeat (HALF) @(posedge ref_clk);
  endtask : hold
  // Start: SDA falls while SCL is high
  task automatic start;
    sdaLow <= 1'b1;
    hold();
    sclOut <= 1'b0;
  endtask : start
  // Stop: SDA rises while SCL is high
  task automatic stop;
    hold();
    sdaLow <= 1'b1;
    hold();
    sclOut <= 1'b1;
    hold();
    sdaLow <= 1'b0;
    hold();
  endtask : stop
  // SDA moves mid-low so it never looks like a start or stop
  task automatic clk_bit(input logic b, output logic s);
    hold();
    sdaLow <= !b;
    hold();
    sclOut <= 1'b1;
    hold();
    s = sdaWire;
    sclOut <= 1'b0;
  endtask : clk_bit
  // Byte out, MSB first; ack seen as SDA low in the ninth clock
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask : wbyte
  // Byte in; the last byte is answered with a nack
  task automatic rbyte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask : rbyte
endmodule : ieol_bus_master

// ===== ieol_latch_monitor.sv
/*
  Checker for the output latch: sink gating, SDA drive and reset.
  Assumes the top module's ports only; attached by bind below.
*/
`timescale 1ns/10ps
module ieol_latch_monitor
  import ieol_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic outEnable_n,
  input wire logic overTemp,
  input wire logic [WIDTH-1:0] sink_outputs
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Four cycles cover the three-flop input latency
  a_sink_off_disabled: assert property (outEnable_n [*4] |->
    sink_outputs == '0) else $error("sinks on while disabled");
  a_sink_off_hot: assert property (overTemp [*4] |->
    sink_outputs == '0) else $error("sinks on while hot");
  a_sda_pull_only: assert property (sdaOut == 1'b0)
    else $error("sda driven high");
  a_reset_clears: assert property (disable iff (1'b0)
    !reset_n |-> sink_outputs == '0 && !sdaOe)
    else $error("outputs live in reset");
  // SDA may only move while SCL is low
  a_sda_turn_low: assert property ($changed(sdaOe) |-> !scl)
    else $error("sda moved with scl high");
  a_ack_holds: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("sda pull too short");
  // Storage only loads after an SCL fall, so high SCL means steady
  a_sink_steady: assert property (
    (!outEnable_n && !overTemp && scl) [*6] |-> $stable(sink_outputs))
    else $error("sinks moved without cause");
  a_idle_after_reset: assert property ($rose(reset_n) |->
    !sdaOe [*3]) else $error("sda pulled after reset");
  c_ack: cover property ($rose(sdaOe));
  c_sink_on: cover property (sink_outputs == 8'hA5);
  c_hot: cover property (overTemp [*4] ##1 !overTemp);
endmodule : ieol_latch_monitor

bind ieol_latch ieol_latch_monitor #(.WIDTH(WIDTH)) i_mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .outEnable_n(outEnable_n), .overTemp(overTemp),
  .sink_outputs(sink_outputs));

// ===== tb_top.sv
/*
  Self-checking bench: master model writes, transfers and reads back.
  Assumes straps 101 and the default group identifier.
*/
`timescale 1ns/10ps
module tb_top
  import ieol_pkg::*;
;
  localparam logic [6:0] DEV = {GROUP_ID_DEF, 3'b101};
  logic ref_clk = 1'b0;
  logic reset_n, sclOut, sdaLow, sdaOut, sdaOe, outEnable_n, overTemp;
  logic [2:0] straps;
  logic [7:0] sinkOut;
  wire logic sdaWire;
  int fails = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  // Pull-up wins unless some party pulls low
  assign sdaWire = !(sdaLow || sdaOe);
  ieol_latch i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl(sclOut),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addr_strap_bit0(straps[0]), .addr_strap_bit1(straps[1]),
    .addr_strap_bit2(straps[2]), .outEnable_n(outEnable_n),
    .overTemp(overTemp), .sink_outputs(sinkOut));
  ieol_bus_master i_master (.ref_clk(ref_clk), .sdaWire(sdaWire),
    .sclOut(sclOut), .sdaLow(sdaLow));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // Address, subaddress and optional data; acks come back MSB first
  task automatic xfer(input logic [6:0] a, input logic [7:0] sub,
    input logic [7:0] d, input logic wd, output logic [7:0] acks);
    acks = 8'h00;
    i_master.start();
    i_master.wbyte({a, 1'b0}, acks[2]);
    if (acks[2]) i_master.wbyte(sub, acks[1]);
    if (wd && acks[1]) i_master.wbyte(d, acks[0]);
    i_master.stop();
  endtask : xfer
  task automatic rd(output logic [7:0] v);
    logic ack;
    i_master.start();
    i_master.wbyte({DEV, 1'b1}, ack);
    i_master.rbyte(v, 1'b1);
    i_master.stop();
    chk({7'h00, ack}, 8'h01);
    chk({7'h00, sdaOut}, 8'h00);
  endtask : rd
  task automatic t_write;
    logic [7:0] a;
    xfer(DEV, SUB_WRITE, 8'hA5, 1'b1, a);
    chk(a, 8'h07);
    chk(sinkOut, 8'h00);
    xfer(DEV, SUB_XFER, 8'h00, 1'b0, a);
    chk(a, 8'h06);
    chk(sinkOut, 8'hA5);
  endtask : t_write
  task automatic t_read;
    logic [7:0] a, v, w;
    logic ack;
    xfer(DEV, SUB_WRITE, 8'h3C, 1'b1, a);
    rd(v);
    chk(v, 8'h3C);
    xfer(DEV, SUB_READ, 8'h00, 1'b0, a);
    rd(v);
    chk(v, 8'hA5);
    // Master ack after the first byte keeps the read going
    i_master.start();
    i_master.wbyte({DEV, 1'b1}, ack);
    i_master.rbyte(v, 1'b0);
    i_master.rbyte(w, 1'b1);
    i_master.stop();
    chk({7'h00, ack}, 8'h01);
    chk(v, 8'hA5);
    chk(w, 8'hA5);
  endtask : t_read
  // Strap and group mismatches and an unknown subaddress are refused
  task automatic t_refuse;
    logic [7:0] a;
    xfer(DEV ^ 7'h01, SUB_WRITE, 8'hFF, 1'b1, a);
    chk(a, 8'h00);
    xfer(DEV ^ 7'h40, SUB_WRITE, 8'hFF, 1'b1, a);
    chk(a, 8'h00);
    xfer(DEV, 8'h33, 8'hFF, 1'b1, a);
    chk(a, 8'h04);
    xfer(DEV, SUB_XFER, 8'h00, 1'b0, a);
    chk(sinkOut, 8'h3C);
  endtask : t_refuse
  // Gate latency is three cycles; five leaves margin
  task automatic t_gate;
    outEnable_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(sinkOut, 8'h00);
    outEnable_n <= 1'b0;
    overTemp <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(sinkOut, 8'h00);
    overTemp <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(sinkOut, 8'h3C);
  endtask : t_gate
  // Mid-run clear must empty storage as well as the pins
  task automatic t_clear;
    logic [7:0] a, v;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(sinkOut, 8'h00);
    chk({7'h00, sdaOe}, 8'h00);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(DEV, SUB_READ, 8'h00, 1'b0, a);
    rd(v);
    chk(v, 8'h00);
  endtask : t_clear
  initial begin
    reset_n = 1'b0;
    outEnable_n = 1'b0;
    overTemp = 1'b0;
    straps = 3'b101;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(sinkOut, 8'h00);
    t_write();
    t_read();
    t_refuse();
    t_gate();
    t_clear();
    report_and_stop();
  end
  // Watchdog well past the roughly 16000 cycles the tests need
  initial begin
    repeat (80000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
endmodule : tb_top
